// ---- common/tmi_pkg.sv ----
package tmi_pkg;
    // message identifiers, inbound
    localparam logic [7:0] ID_VOLUME_UP = 8'h33; // 051
    localparam logic [7:0] ID_VOLUME_DOWN = 8'h34; // 052
    localparam logic [7:0] ID_STATUS_REQ = 8'h35; // 053
    localparam logic [7:0] ID_INDICATION_REQ = 8'h36; // 054
    localparam logic [7:0] ID_POWER_REQ = 8'h37; // 055
    localparam logic [7:0] ID_ALERT_REQ = 8'h38; // 056
    localparam logic [7:0] ID_SHORT_MSG_REQ = 8'h39; // 057
    localparam logic [7:0] ID_KEYSTROKE = 8'h3A; // 058
    localparam logic [7:0] ID_HOOK_ON = 8'h40; // 064
    localparam logic [7:0] ID_HOOK_OFF = 8'h41; // 065
    localparam logic [7:0] ID_BEARER_SELECT = 8'h46; // 070
    localparam logic [7:0] ID_SET_POWER = 8'h50; // 080
    localparam logic [7:0] ID_FULL_RESET = 8'hFF; // 255
    // message identifiers, outbound
    localparam logic [7:0] ID_ALERT_ON = 8'h3C; // 060
    localparam logic [7:0] ID_ALERT_OFF = 8'h3D; // 061
    localparam logic [7:0] ID_STATUS_RSP = 8'h5B; // 091
    localparam logic [7:0] ID_INDICATION_RSP = 8'h5C; // 092
    localparam logic [7:0] ID_POWER_RSP = 8'h5D; // 093
    localparam logic [7:0] ID_SHORT_MSG_RPT = 8'h65; // 101
    localparam logic [7:0] ID_NO_SHORT_MSG = 8'h66; // 102
    localparam logic [7:0] ID_INTERNAL_FAULT = 8'hF0; // 240
    localparam logic [7:0] ID_UNRECOGNIZED = 8'hF1; // 241
    localparam logic [7:0] ID_NOT_PERFORMABLE = 8'hF2; // 242
    // key codes
    localparam logic [7:0] KEY_HASH = 8'h23; // 35
    localparam logic [7:0] KEY_STAR = 8'h2A; // 42
    localparam logic [7:0] KEY_PLUS = 8'h2B; // 43
    localparam logic [7:0] KEY_DIGIT_0 = 8'h30; // 48
    localparam logic [7:0] KEY_DIGIT_9 = 8'h39; // 57
    localparam logic [7:0] KEY_END = 8'h12; // 18
    localparam logic [7:0] KEY_SEND = 8'h14; // 20
    // layer-2 flow control octets an identifier must never equal
    localparam logic [7:0] L2_ACK = 8'h06;
    localparam logic [7:0] L2_NAK = 8'h15;
    localparam logic [7:0] L2_XON = 8'h11;
    localparam logic [7:0] L2_XOFF = 8'h13;
    localparam logic [7:0] L2_STX = 8'h02;
    localparam logic [7:0] L2_ETX = 8'h03;
    // reset values
    localparam logic [3:0] VOLUME_RESET = 4'h4;
    localparam logic [7:0] POWER_RESET = 8'h00;

    // one octet of a layer-3 message with framing marks
    typedef struct packed {
        logic first;
        logic last;
        logic [7:0] data;
    } tmi_octet_t;

    // decoded keystroke event
    typedef struct packed {
        logic valid;
        logic is_digit;
        logic [3:0] digit;
        logic is_hash;
        logic is_star;
        logic is_plus;
        logic is_end;
        logic is_send;
    } tmi_key_t;
endpackage

// ---- core/tmi_interpreter.sv ----
`timescale 1ns/10ps
module tmi_interpreter #(
    parameter int BEARER_BYTES = 16,
    parameter int VOLUME_STEPS = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    // received layer-3 octets from the framing layer
    input wire tmi_pkg::tmi_octet_t rx_octet,
    input wire logic rx_valid,
    // handset state that responses report
    input wire logic alert_active,
    input wire logic short_msg_stored,
    input wire logic fault_detected,
    // reply identifier toward the framing layer
    output logic [7:0] tx_id,
    output logic tx_valid,
    input wire logic tx_ready,
    // handset actions
    output logic [3:0] volume_level,
    output logic hook_on_pulse,
    output logic hook_off_pulse,
    output tmi_pkg::tmi_key_t key_event,
    output logic [7:0] power_level,
    output logic power_set_pulse,
    output logic [7:0] bearer_len,
    output logic [8*BEARER_BYTES-1:0] bearer_field,
    output logic bearer_set_pulse,
    output logic soft_reset_pulse
);
    typedef enum {TMI_IDLE, TMI_KEYS, TMI_BEARER, TMI_POWER, TMI_SKIP}
        tmi_state_t;

    logic rst_meta;
    logic rst_sync;
    logic soft_rst;
    tmi_state_t state;
    logic [7:0] bearer_idx;
    logic [7:0] last_tx;
    logic bearer_ok;
    logic power_seen;
    logic key_bad;

    // release reset through two flops; the async assert stays immediate
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    wire logic rx_take = rx_valid && (state != TMI_IDLE || !tx_valid);
    wire logic [7:0] rd = rx_octet.data;

    // an identifier the handset acts on; 210-239 never arrive
    // ids 0-49 and the layer-2 control octets never match
    function automatic logic known_id(input logic [7:0] id);
        logic k;
        k = 1'b0;
        if (id == tmi_pkg::ID_VOLUME_UP || id == tmi_pkg::ID_VOLUME_DOWN)
            k = 1'b1;
        else if (id >= tmi_pkg::ID_STATUS_REQ && id <= tmi_pkg::ID_KEYSTROKE)
            k = 1'b1;
        else if (id == tmi_pkg::ID_HOOK_ON || id == tmi_pkg::ID_HOOK_OFF)
            k = 1'b1;
        else if (id == tmi_pkg::ID_BEARER_SELECT ||
                 id == tmi_pkg::ID_SET_POWER)
            k = 1'b1;
        else if (id == tmi_pkg::ID_UNRECOGNIZED ||
                 id == tmi_pkg::ID_FULL_RESET)
            k = 1'b1;
        return k;
    endfunction

    // full reset is a pulse that clears all state on the next edge
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            soft_rst <= 1'b0;
        else
            soft_rst <= rx_take && rx_octet.first &&
                        rd == tmi_pkg::ID_FULL_RESET;
    end

    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            soft_reset_pulse <= 1'b0;
        else
            soft_reset_pulse <= soft_rst;
    end

    // message parser; the first octet is always the identifier
    // operands of any length are consumed up to the last mark
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            state <= TMI_IDLE;
        else if (soft_rst)
            state <= TMI_IDLE;
        else if (rx_take)
        begin
            if (rx_octet.first && !rx_octet.last)
            begin
                case (rd)
                    tmi_pkg::ID_KEYSTROKE: state <= TMI_KEYS;
                    tmi_pkg::ID_BEARER_SELECT: state <= TMI_BEARER;
                    tmi_pkg::ID_SET_POWER: state <= TMI_POWER;
                    default: state <= TMI_SKIP;
                endcase
            end
            else if (rx_octet.last)
                state <= TMI_IDLE;
        end
    end

    // keystroke decode, one key per octet
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            key_event <= '0;
        else
        begin
            key_event <= '0;
            if (rx_take && !rx_octet.first && state == TMI_KEYS &&
                !soft_rst)
            begin
                key_event.valid <= 1'b1;
                if (rd >= tmi_pkg::KEY_DIGIT_0 &&
                    rd <= tmi_pkg::KEY_DIGIT_9)
                begin
                    key_event.is_digit <= 1'b1;
                    key_event.digit <= rd[3:0];
                end
                key_event.is_hash <= rd == tmi_pkg::KEY_HASH;
                key_event.is_star <= rd == tmi_pkg::KEY_STAR;
                key_event.is_plus <= rd == tmi_pkg::KEY_PLUS;
                key_event.is_end <= rd == tmi_pkg::KEY_END;
                key_event.is_send <= rd == tmi_pkg::KEY_SEND;
            end
        end
    end

    function automatic logic key_known(input logic [7:0] k);
        return (k >= tmi_pkg::KEY_DIGIT_0 && k <= tmi_pkg::KEY_DIGIT_9) ||
               k == tmi_pkg::KEY_HASH || k == tmi_pkg::KEY_STAR ||
               k == tmi_pkg::KEY_PLUS || k == tmi_pkg::KEY_END ||
               k == tmi_pkg::KEY_SEND;
    endfunction

    // one bad key spoils the whole sequence, not only the last octet;
    // keys ahead of it have already gone out, there is no key buffer
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            key_bad <= 1'b0;
        else if (soft_rst || (rx_take && rx_octet.first))
            key_bad <= 1'b0;
        else if (rx_take && state == TMI_KEYS && !key_known(rd))
            key_bad <= 1'b1;
    end

    // volume saturates at the ends; a step is always exactly one
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            volume_level <= tmi_pkg::VOLUME_RESET;
        else if (soft_rst)
            volume_level <= tmi_pkg::VOLUME_RESET;
        else if (rx_take && rx_octet.first && rx_octet.last)
        begin
            if (rd == tmi_pkg::ID_VOLUME_UP &&
                volume_level < 4'(VOLUME_STEPS - 1))
                volume_level <= volume_level + 4'h1;
            else if (rd == tmi_pkg::ID_VOLUME_DOWN && volume_level != 4'h0)
                volume_level <= volume_level - 4'h1;
        end
    end

    // hook strobes feed the same path as the physical hook switch
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            hook_on_pulse <= 1'b0;
            hook_off_pulse <= 1'b0;
        end
        else
        begin
            hook_on_pulse <= rx_take && rx_octet.first && !soft_rst &&
                             rd == tmi_pkg::ID_HOOK_ON;
            hook_off_pulse <= rx_take && rx_octet.first && !soft_rst &&
                              rd == tmi_pkg::ID_HOOK_OFF;
        end
    end

    // bearer field: length octet then contents, kept until power-off
    // or the next selection; a full reset counts as power-off
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            bearer_idx <= 8'h00;
            bearer_len <= 8'h00;
            bearer_field <= '0;
            bearer_set_pulse <= 1'b0;
        end
        else if (soft_rst)
        begin
            bearer_idx <= 8'h00;
            bearer_len <= 8'h00;
            bearer_field <= '0;
            bearer_set_pulse <= 1'b0;
        end
        else
        begin
            bearer_set_pulse <= 1'b0;
            if (rx_take && rx_octet.first)
                bearer_idx <= 8'h00;
            else if (rx_take && state == TMI_BEARER)
            begin
                if (bearer_idx == 8'h00)
                    bearer_len <= rd; // length, not identifier
                else if (bearer_idx <= 8'(BEARER_BYTES))
                    bearer_field[8*(bearer_idx-8'h01) +: 8] <= rd;
                bearer_idx <= bearer_idx + 8'h01;
                bearer_set_pulse <= rx_octet.last;
            end
        end
    end

    // power level is the operand octet
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            power_level <= tmi_pkg::POWER_RESET;
            power_set_pulse <= 1'b0;
            power_seen <= 1'b0;
        end
        else if (soft_rst)
        begin
            power_level <= tmi_pkg::POWER_RESET;
            power_set_pulse <= 1'b0;
            power_seen <= 1'b0;
        end
        else
        begin
            power_set_pulse <= 1'b0;
            if (rx_take && rx_octet.first)
                power_seen <= 1'b0;
            else if (rx_take && state == TMI_POWER && !power_seen)
            begin
                power_level <= rd;
                power_set_pulse <= 1'b1;
                power_seen <= 1'b1;
            end
        end
    end

    // a bearer message without contents can not be performed
    assign bearer_ok = bearer_idx != 8'h00 || state != TMI_BEARER;

    // reply selection at message end; one reply outstanding at a time,
    // so further messages wait on tx_ready (no reply queue)
    always_ff @(posedge sys_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            tx_id <= 8'h00;
            tx_valid <= 1'b0;
            last_tx <= 8'h00;
        end
        else if (soft_rst)
        begin
            tx_id <= 8'h00;
            tx_valid <= 1'b0;
            last_tx <= 8'h00;
        end
        else if (tx_valid)
        begin
            if (tx_ready)
                tx_valid <= 1'b0;
        end
        else if (rx_take && rx_octet.last)
        begin
            tx_valid <= 1'b1;
            if (rx_octet.first && !known_id(rd))
                tx_id <= tmi_pkg::ID_UNRECOGNIZED;
            else if (fault_detected)
                tx_id <= tmi_pkg::ID_INTERNAL_FAULT;
            else if (state == TMI_KEYS && (key_bad || !key_known(rd)))
                tx_id <= tmi_pkg::ID_UNRECOGNIZED;
            else if (!bearer_ok || (rx_octet.first &&
                     (rd == tmi_pkg::ID_BEARER_SELECT ||
                      rd == tmi_pkg::ID_SET_POWER ||
                      rd == tmi_pkg::ID_KEYSTROKE)))
                tx_id <= tmi_pkg::ID_NOT_PERFORMABLE;
            else if (!rx_octet.first)
                tx_valid <= 1'b0;
            else if (rd == tmi_pkg::ID_UNRECOGNIZED)
            begin
                tx_id <= last_tx;
                tx_valid <= last_tx != 8'h00;
            end
            else if (rd == tmi_pkg::ID_STATUS_REQ)
                tx_id <= tmi_pkg::ID_STATUS_RSP;
            else if (rd == tmi_pkg::ID_INDICATION_REQ)
                tx_id <= tmi_pkg::ID_INDICATION_RSP;
            else if (rd == tmi_pkg::ID_POWER_REQ)
                tx_id <= tmi_pkg::ID_POWER_RSP;
            else if (rd == tmi_pkg::ID_ALERT_REQ)
                tx_id <= alert_active ? tmi_pkg::ID_ALERT_ON
                                      : tmi_pkg::ID_ALERT_OFF;
            else if (rd == tmi_pkg::ID_SHORT_MSG_REQ)
                tx_id <= short_msg_stored ? tmi_pkg::ID_SHORT_MSG_RPT :
                         tmi_pkg::ID_NO_SHORT_MSG;
            else
                tx_valid <= 1'b0;
        end
        else if (tx_valid == 1'b0 && tx_id != 8'h00)
            last_tx <= tx_id; // remembered for resend requests
    end
endmodule // tmi_interpreter

// ---- test/tmi_interpreter_sva.sv ----
`timescale 1ns/10ps
module tmi_interpreter_sva #(
    parameter int BEARER_BYTES = 16,
    parameter int VOLUME_STEPS = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire tmi_pkg::tmi_octet_t rx_octet,
    input wire logic rx_valid,
    input wire logic alert_active,
    input wire logic fault_detected,
    input wire logic [7:0] tx_id,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [3:0] volume_level,
    input wire logic hook_on_pulse,
    input wire logic soft_reset_pulse
);
    logic take;
    logic [3:0] vol_at_take;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // a one-octet message accepted at this edge
    assign take = rx_valid && rx_octet.first && rx_octet.last && !tx_valid;
    // volume seen when the message was taken, for the step checks
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            vol_at_take <= 4'h0;
        else if (take)
            vol_at_take <= volume_level;
    end
    reply_hold_a: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_id)) else $error("reply dropped early");
    reply_ack_a: assert property (tx_valid && tx_ready |=>
        !tx_valid) else $error("reply kept after accept");
    ind_answer_a: assert property (take && !fault_detected &&
        rx_octet.data == tmi_pkg::ID_INDICATION_REQ |=> tx_valid &&
        tx_id == tmi_pkg::ID_INDICATION_RSP) else $error("bad table reply");
    alert_answer_a: assert property (take && !fault_detected &&
        rx_octet.data == tmi_pkg::ID_ALERT_REQ |=> tx_id == ($past(alert_active)
        ? tmi_pkg::ID_ALERT_ON : tmi_pkg::ID_ALERT_OFF))
        else $error("bad alert reply");
    fault_reply_a: assert property (take && fault_detected &&
        rx_octet.data == tmi_pkg::ID_STATUS_REQ |=>
        tx_id == tmi_pkg::ID_INTERNAL_FAULT) else $error("fault not reported");
    unknown_id_a: assert property (take && !fault_detected &&
        rx_octet.data == 8'h64 |=> tx_id == tmi_pkg::ID_UNRECOGNIZED)
        else $error("unknown id not refused");
    vol_up_a: assert property (take &&
        rx_octet.data == tmi_pkg::ID_VOLUME_UP &&
        volume_level < VOLUME_STEPS - 1 |-> ##[1:3]
        volume_level == vol_at_take + 4'h1) else $error("volume up wrong");
    vol_down_a: assert property (take && volume_level != 4'h0 &&
        rx_octet.data == tmi_pkg::ID_VOLUME_DOWN |-> ##[1:3]
        volume_level == vol_at_take - 4'h1) else $error("volume down wrong");
    vol_range_a: assert property (
        volume_level <= VOLUME_STEPS - 1) else $error("volume out of range");
    hook_on_a: assert property (take &&
        rx_octet.data == tmi_pkg::ID_HOOK_ON |-> ##[1:3]
        hook_on_pulse ##1 !hook_on_pulse) else $error("hook on pulse wrong");
    full_reset_a: assert property (take &&
        rx_octet.data == tmi_pkg::ID_FULL_RESET |-> ##[1:3] soft_reset_pulse)
        else $error("no reset pulse");
    ctrl_clash_a: assert property (tx_valid |->
        tx_id != tmi_pkg::L2_ACK && tx_id != tmi_pkg::L2_NAK &&
        tx_id != tmi_pkg::L2_XON && tx_id != tmi_pkg::L2_XOFF &&
        tx_id != tmi_pkg::L2_STX && tx_id != tmi_pkg::L2_ETX)
        else $error("reply equals a flow-control octet");
    cover property (take && rx_octet.data == tmi_pkg::ID_KEYSTROKE);
    cover property (tx_valid && !tx_ready ##1 tx_valid);
    cover property (soft_reset_pulse);
endmodule // tmi_interpreter_sva

bind tmi_interpreter tmi_interpreter_sva #(.BEARER_BYTES(BEARER_BYTES),
    .VOLUME_STEPS(VOLUME_STEPS)) i_tmi_interpreter_sva (.sys_clk(sys_clk),
    .rst_n(rst_n), .rx_octet(rx_octet), .rx_valid(rx_valid),
    .alert_active(alert_active), .fault_detected(fault_detected),
    .tx_id(tx_id), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .volume_level(volume_level), .hook_on_pulse(hook_on_pulse),
    .soft_reset_pulse(soft_reset_pulse));

// ---- test/tmi_sim_model.sv ----
`timescale 1ns/10ps
// far-side test simulator: sends messages, takes replies, can stall
module tmi_sim_model (
    input wire logic sys_clk,
    output tmi_pkg::tmi_octet_t rx_octet,
    output logic rx_valid,
    input wire logic [7:0] tx_id,
    input wire logic tx_valid,
    output logic tx_ready
);
    int ready_delay = 0;
    int wait_cnt = 0;
    logic [7:0] replies[$];
    initial
    begin
        rx_octet = '0;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    // only general and error-range ids are sent, never 210-239
    // the full reset id is sent only from this side
    task automatic send(input logic [7:0] m[$]);
        @(posedge sys_clk);
        while (tx_valid !== 1'b0)
            @(posedge sys_clk);
        foreach (m[i])
        begin
            // id first, operands after, each held one edge
            rx_octet <= '{first: i == 0, last: i == m.size() - 1, data: m[i]};
            rx_valid <= 1'b1;
            @(posedge sys_clk);
        end
        rx_valid <= 1'b0;
        rx_octet <= ~rx_octet; // released data must not keep its last value
        repeat (2) @(posedge sys_clk);
    endtask
    // accept replies after ready_delay cycles so stalls get exercised
    always @(posedge sys_clk)
    begin
        if (tx_valid === 1'b1 && tx_ready)
        begin
            replies.push_back(tx_id);
            tx_ready <= 1'b0;
            wait_cnt <= 0;
        end
        else if (tx_valid === 1'b1)
        begin
            tx_ready <= wait_cnt >= ready_delay;
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule // tmi_sim_model

// ---- test/tmi_interpreter_tb_top.sv ----
`timescale 1ns/10ps
module tmi_interpreter_tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic alert_active = 1'b0;
    logic short_msg_stored = 1'b0;
    logic fault_detected = 1'b0;
    tmi_pkg::tmi_octet_t rx_octet;
    tmi_pkg::tmi_key_t key_event;
    logic rx_valid, tx_valid, tx_ready, hook_on_pulse, hook_off_pulse;
    logic power_set_pulse, bearer_set_pulse, soft_reset_pulse;
    logic [7:0] tx_id, power_level, bearer_len;
    logic [3:0] volume_level;
    logic [127:0] bearer_field;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int pulses[5] = '{0, 0, 0, 0, 0};
    tmi_pkg::tmi_key_t keys[$];
    always #5 sys_clk = ~sys_clk;
    tmi_interpreter i_tmi_interpreter (.sys_clk(sys_clk), .rst_n(rst_n),
        .rx_octet(rx_octet), .rx_valid(rx_valid), .alert_active(alert_active),
        .short_msg_stored(short_msg_stored), .fault_detected(fault_detected),
        .tx_id(tx_id), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .volume_level(volume_level), .hook_on_pulse(hook_on_pulse),
        .hook_off_pulse(hook_off_pulse), .key_event(key_event),
        .power_level(power_level), .power_set_pulse(power_set_pulse),
        .bearer_len(bearer_len), .bearer_field(bearer_field),
        .bearer_set_pulse(bearer_set_pulse),
        .soft_reset_pulse(soft_reset_pulse));
    tmi_sim_model i_tmi_sim_model (.sys_clk(sys_clk), .rx_octet(rx_octet),
        .rx_valid(rx_valid), .tx_id(tx_id), .tx_valid(tx_valid),
        .tx_ready(tx_ready));
    // pulses and key events are tallied mid-cycle, clear of the edge race
    always @(negedge sys_clk)
    begin
        pulses[0] += int'(hook_on_pulse === 1'b1);
        pulses[1] += int'(hook_off_pulse === 1'b1);
        pulses[2] += int'(power_set_pulse === 1'b1);
        pulses[3] += int'(bearer_set_pulse === 1'b1);
        pulses[4] += int'(soft_reset_pulse === 1'b1);
        if (key_event.valid === 1'b1)
            keys.push_back(key_event);
    end
    // a hang is cut short well past the expected run length
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic check(input string name, input logic [127:0] exp, got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic reply(input logic [7:0] m[$], input logic [7:0] exp);
        logic [7:0] got;
        int n;
        got = 'x;
        n = 0;
        i_tmi_sim_model.send(m);
        while (i_tmi_sim_model.replies.size() == 0 && n < 100)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (i_tmi_sim_model.replies.size() != 0)
            got = i_tmi_sim_model.replies.pop_front();
        check("reply id", {120'h0, exp}, {120'h0, got});
    endtask
    function automatic tmi_pkg::tmi_key_t exp_key(input logic [7:0] c);
        exp_key = '0;
        exp_key.valid = 1'b1;
        exp_key.is_digit = c >= 8'h30 && c <= 8'h39;
        exp_key.digit = exp_key.is_digit ? c[3:0] : 4'h0;
        exp_key.is_hash = c == 8'h23;
        exp_key.is_star = c == 8'h2A;
        exp_key.is_plus = c == 8'h2B;
        exp_key.is_end = c == 8'h12;
        exp_key.is_send = c == 8'h14;
    endfunction
    task automatic t_tables();
        i_tmi_sim_model.ready_delay = 4; // replies stall before acceptance
        reply('{8'h35}, 8'h5B);
        reply('{8'h36}, 8'h5C);
        reply('{8'h37}, 8'h5D);
        i_tmi_sim_model.ready_delay = 0;
        reply('{8'h38}, 8'h3D);
        alert_active <= 1'b1;
        reply('{8'h38}, 8'h3C);
        reply('{8'h39}, 8'h66);
        short_msg_stored <= 1'b1;
        reply('{8'h39}, 8'h65);
    endtask
    task automatic t_volume();
        check("volume", 128'h4, {124'h0, volume_level});
        i_tmi_sim_model.send('{8'h33});
        check("volume", 128'h5, {124'h0, volume_level});
        repeat (4) i_tmi_sim_model.send('{8'h33});
        check("volume", 128'h7, {124'h0, volume_level});
        repeat (8) i_tmi_sim_model.send('{8'h34});
        check("volume", 128'h0, {124'h0, volume_level});
    endtask
    task automatic t_keys_hook();
        logic [7:0] m[$] = '{8'h3A, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35,
            8'h36, 8'h37, 8'h38, 8'h39, 8'h23, 8'h2A, 8'h2B, 8'h12, 8'h14};
        keys.delete();
        i_tmi_sim_model.send(m);
        check("key count", 128'd15, 128'(keys.size()));
        for (int i = 1; i < 16 && keys.size() != 0; i++)
            check("key", exp_key(m[i]),
                  keys.pop_front());
        reply('{8'h3A, 8'h41}, 8'hF1);
        reply('{8'h3A, 8'h41, 8'h30}, 8'hF1);
        reply('{8'h3A}, 8'hF2);
        i_tmi_sim_model.send('{8'h40});
        i_tmi_sim_model.send('{8'h41});
        check("hook on", 128'h1, 128'(pulses[0]));
        check("hook off", 128'h1, 128'(pulses[1]));
    endtask
    task automatic t_bearer_power();
        i_tmi_sim_model.send('{8'h46, 8'h02, 8'hA1, 8'hB2});
        check("bearer len", 128'h2, {120'h0, bearer_len});
        check("bearer", 128'hB2A1, {112'h0, bearer_field[15:0]});
        reply('{8'h46}, 8'hF2);
        check("bearer len", 128'h2, {120'h0, bearer_len});
        i_tmi_sim_model.send('{8'h50, 8'h07, 8'h09});
        check("power", 128'h7, {120'h0, power_level});
        check("set pulses", 128'h2, 128'(pulses[2] + pulses[3]));
        reply('{8'h50}, 8'hF2);
    endtask
    task automatic t_errors();
        reply('{8'h64}, 8'hF1);
        reply('{8'h20}, 8'hF1);
        reply('{8'h15}, 8'hF1);
        reply('{8'h36}, 8'h5C);
        reply('{8'hF1}, 8'h5C);
        fault_detected <= 1'b1;
        reply('{8'h35}, 8'hF0);
        fault_detected <= 1'b0;
        i_tmi_sim_model.send('{8'hFF});
        @(posedge sys_clk); // the clear lands one edge after the id is taken
        check("reset pulse", 128'h1, 128'(pulses[4]));
        check("volume", 128'h4, {124'h0, volume_level});
        check("power", 128'h0, {120'h0, power_level});
        check("bearer len", 128'h0, {120'h0, bearer_len});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_volume();
        t_tables();
        t_keys_hook();
        t_bearer_power();
        t_errors();
        end_of_test();
    end
endmodule // tmi_interpreter_tb_top
